// ==== verilog/mcc_pkg.sv ====
// constants and carrier types for the processor-side memory cycle control block
// assumes a 50 MHz core clock; all processor pins reach the block as plain inputs
// Function
// - ignore A1:A0 on words, decode A3:A2
// - read when direction low, write when high
// - byte-not-word low selects byte lane on writes
// - word transfers forced to word alignment
// - request low starts access next cycle
// - request plus hint in idle starts early
// - hint high gives one-clock page cycle unless A3:A2 == 0
// - hint low precharges then two-clock cycle
// - user mode denied privileged regions, aborted
// - non-user transfers bypass address remapping
// - two clock phases at master divided three
// - phase two in phase with reference clock
// - bus drive enable high on writes only
// - early control inputs registered for next cycle
// - reset selects slow rom, large page, no io
// - four column strobes, one per byte
package mcc_pkg;
    localparam int ADDR_W = 26;
    localparam int LANES = 4;
    localparam int DIV_COUNT = 3;          // master periods per processor cycle
    localparam logic [1:0] PH1_SLOT = 2'h0; // phase one high in this slot
    localparam logic [1:0] PH2_SLOT = 2'h2; // phase two high in this slot
    localparam logic [1:0] LAST_SLOT = 2'h2;
    localparam logic [1:0] ROM_SLOW = 2'h0; // slowest rom timing code
    localparam logic PAGE_LARGE = 1'h1;
    // memory map: logical ram below, physical/privileged above
    localparam logic [1:0] REG_PRIV = 2'h3; // A25:A24 == 3 : privileged area
    localparam logic [1:0] REG_IO = 2'h2;   // A25:A24 == 2 : io space
    localparam logic [1:0] REG_ROM = 2'h1;  // A25:A24 == 1 : rom
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rdWrite;     // high is write
        logic byteWord;    // high is word
        logic reqN;
        logic seqHint;
        logic superSel;
    } mcc_cpu_req_type;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PRE  = 4'h2,
        ST_ROW  = 4'h4,
        ST_COL  = 4'h8
    } mcc_state_type;
endpackage : mcc_pkg

// ==== verilog/mcc_clock_gen.sv ====
// processor two-phase clock and reference clock divider
// assumes core_clk is the master clock and rstn is synchronous active low
`timescale 1ns/100ps
module mcc_clock_gen
    import mcc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    output logic phase1Clk,
    output logic phase2Clk,
    output logic refClk,
    output logic cycleEnd
);
    logic [1:0] slot_ff;
    wire logic [1:0] nxt_slot = (slot_ff == LAST_SLOT) ? 2'h0 : slot_ff + 2'h1;

    // slot 1 low for both phases gives one master period of dead time
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            slot_ff <= 2'h0;
            phase1Clk <= 1'b0;
            phase2Clk <= 1'b0;
            refClk <= 1'b0;
        end else begin
            slot_ff <= nxt_slot;
            phase1Clk <= (nxt_slot == PH1_SLOT);
            phase2Clk <= (nxt_slot == PH2_SLOT);
            refClk <= (nxt_slot == PH2_SLOT);
        end
    end

    assign cycleEnd = (slot_ff == LAST_SLOT);

    phasesApart_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !(phase1Clk && phase2Clk)) else $error("phases overlap");
    refTrack_a: assert property (@(posedge core_clk) disable iff (!rstn)
        refClk == phase2Clk) else $error("ref clock out of phase");
    divThree_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(phase1Clk) |-> ##3 $rose(phase1Clk)) else $error("not divide by three");
endmodule : mcc_clock_gen

// ==== verilog/mcc_cycle_ctrl.sv ====
// processor-facing memory cycle sequencer: strobes, drive enable, abort
// assumes processor pins arrive asynchronously and are synchronised here
`timescale 1ns/100ps
module mcc_cycle_ctrl
    import mcc_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [AW-1:0] cpu_addr,
    input wire logic cpu_read_not_write,
    input wire logic cpu_byte_not_word,
    input wire logic cpu_cycle_request_n,
    input wire logic sequential_hint,
    input wire logic supervisor_select,
    input wire logic page_present,
    input wire logic reset_hold,
    output logic phase1Clk_ff,
    output logic phase2Clk_ff,
    output logic refClk_ff,
    output logic rowStrobeN_ff,
    output logic [LANES-1:0] colStrobeN_ff,
    output logic cpu_bus_drive_enable_ff,
    output logic access_fault_ff,
    output logic romSelectN_ff,
    output logic io_cycle_request_n_ff,
    output logic [1:0] romSpeed_ff,
    output logic pageLarge_ff,
    output logic osMode_ff,
    output logic soundEnable_ff,
    output logic remapBypass_ff,
    output logic [AW-1:0] physAddr_ff
);
    // three-stage synchronisers for every pin except page_present, which is used directly; change taken when stages 2 and 3 agree
    localparam int SW = AW + 6;
    // idle vector: request pin high (bit 3), so reset never fakes an access
    localparam logic [SW-1:0] PIN_IDLE = {{(SW-4){1'b0}}, 4'h8};
    logic [SW-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
    wire logic [SW-1:0] pinRaw = {cpu_addr, cpu_read_not_write, cpu_byte_not_word,
        cpu_cycle_request_n, sequential_hint, supervisor_select, reset_hold};
    wire logic [SW-1:0] agree = ~(s2_ff ^ s3_ff);
    wire logic [SW-1:0] nxt_pin = (pin_ff & ~agree) | (s3_ff & agree);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s1_ff <= PIN_IDLE;
            s2_ff <= PIN_IDLE;
            s3_ff <= PIN_IDLE;
            pin_ff <= PIN_IDLE; // request idle until first sample
        end else begin
            s1_ff <= pinRaw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // unpack the filtered pins into the carrier
    mcc_cpu_req_type cur;
    assign cur = mcc_cpu_req_type'(pin_ff[SW-1:1]);
    wire logic resetHold = pin_ff[0];

    // processor clocks; the processor relies on phase two to move its address
    logic ph1, ph2, rclk, cycleEnd;
    mcc_clock_gen u_clk (
        .core_clk(core_clk),
        .rstn(rstn),
        .phase1Clk(ph1),
        .phase2Clk(ph2),
        .refClk(rclk),
        .cycleEnd(cycleEnd)
    );

    function automatic logic [LANES-1:0] laneMask(input logic isWord, input logic [1:0] lo);
        laneMask = isWord ? {LANES{1'b1}} : (4'h1 << lo);
    endfunction : laneMask

    // control inputs sampled at the end of a processor cycle for use in the next
    mcc_cpu_req_type held_ff;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            held_ff <= '{addr: '0, rdWrite: 1'b0, byteWord: 1'b1, reqN: 1'b1,
                         seqHint: 1'b0, superSel: 1'b0};
        end else if (cycleEnd) begin
            held_ff <= cur;
        end
    end

    // address decode; word transfers drop the two byte bits
    wire logic [AW-1:0] alignedAddr = held_ff.byteWord ? {held_ff.addr[AW-1:2], 2'b00}
                                                       : held_ff.addr;
    wire logic [1:0] region = held_ff.addr[AW-1:AW-2];
    wire logic [1:0] wordInLine = held_ff.addr[3:2];
    wire logic lineWrap = held_ff.seqHint && (wordInLine == 2'h0);
    wire logic reqActive = !held_ff.reqN;
    wire logic isRom = reqActive && (region == REG_ROM);
    wire logic isIo = reqActive && (region == REG_IO);
    wire logic isRam = reqActive && !region[1] && !isRom;
    // user mode may not touch the privileged region; missing pages also fault
    wire logic privFault = reqActive && !held_ff.superSel && (region == REG_PRIV);
    wire logic pageFault = isRam && !page_present;
    wire logic fault = privFault || pageFault;
    // idle cycle with request and hint for next: open the row early
    wire logic earlyOpen = held_ff.reqN && !cur.reqN && cur.seqHint;
    wire logic isWrite = held_ff.rdWrite;
    wire logic [LANES-1:0] lanes = laneMask(held_ff.byteWord, held_ff.addr[1:0]);

    // dram sequencer, advanced once per processor cycle
    mcc_state_type state_ff, nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (isRam && !fault) nxt_state = ST_ROW;
                else if (earlyOpen) nxt_state = ST_ROW;
            end
            ST_PRE: begin
                nxt_state = (isRam && !fault) ? ST_ROW : ST_IDLE;
            end
            ST_ROW: begin
                nxt_state = ST_COL;
            end
            ST_COL: begin
                // sequential inside the same four-word line keeps the row open; a hint at A3:A2 == 0 precharges
                if (isRam && !fault && held_ff.seqHint && !lineWrap)
                    nxt_state = ST_COL;
                else
                    nxt_state = ST_PRE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // strobes: column strobe only in the column state, in the two slots where phase one is low
    wire logic colSlot = (state_ff == ST_COL) && !ph1;
    wire logic rowOn = (state_ff == ST_ROW) || (state_ff == ST_COL);
    wire logic [LANES-1:0] nxt_col = colSlot ? ~(isWrite ? lanes : {LANES{1'b1}})
                                             : {LANES{1'b1}};

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
        end else if (cycleEnd) begin
            state_ff <= resetHold ? ST_IDLE : nxt_state;
        end
    end

    // pin outputs, each from a flip-flop
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase1Clk_ff <= 1'b0;
            phase2Clk_ff <= 1'b0;
            refClk_ff <= 1'b0;
            rowStrobeN_ff <= 1'b1;
            colStrobeN_ff <= {LANES{1'b1}};
            cpu_bus_drive_enable_ff <= 1'b0;
            access_fault_ff <= 1'b0;
            romSelectN_ff <= 1'b0;
            io_cycle_request_n_ff <= 1'b1;
            physAddr_ff <= '0;
            remapBypass_ff <= 1'b0;
        end else begin
            phase1Clk_ff <= ph1;
            phase2Clk_ff <= ph2;
            refClk_ff <= rclk;
            rowStrobeN_ff <= !rowOn;
            colStrobeN_ff <= nxt_col;
            cpu_bus_drive_enable_ff <= reqActive && isWrite;
            access_fault_ff <= fault;
            romSelectN_ff <= !(resetHold || (isRom && !fault));
            io_cycle_request_n_ff <= resetHold || !isIo || fault;
            physAddr_ff <= alignedAddr;
            remapBypass_ff <= held_ff.superSel;
        end
    end

    // configuration forced while reset pin held
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            romSpeed_ff <= ROM_SLOW;
            pageLarge_ff <= PAGE_LARGE;
            osMode_ff <= 1'b0;
            soundEnable_ff <= 1'b0;
        end else if (resetHold) begin
            romSpeed_ff <= ROM_SLOW;
            pageLarge_ff <= PAGE_LARGE;
            osMode_ff <= 1'b0;
            soundEnable_ff <= 1'b0;
        end
    end

    dbeWrite_a: assert property (@(posedge core_clk) disable iff (!rstn)
        cpu_bus_drive_enable_ff |-> $past(isWrite)) else $error("drive enable on read");
    faultCause_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(privFault) |-> access_fault_ff) else $error("missed privilege abort");
    ioReset_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(resetHold) |-> io_cycle_request_n_ff && !romSelectN_ff)
        else $error("io or rom wrong in reset");
    byteLane_a: assert property (@(posedge core_clk) disable iff (!rstn)
        colSlot && isWrite && !held_ff.byteWord |=> $countones(~colStrobeN_ff) == 1)
        else $error("byte write drove several lanes");
    wordAlign_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(held_ff.byteWord) |-> physAddr_ff[1:0] == 2'b00) else $error("word unaligned");
    sequence seqStay_s;
        cycleEnd && state_ff == ST_COL && isRam && !fault && held_ff.seqHint && !lineWrap;
    endsequence
    pageMode_a: assert property (@(posedge core_clk) disable iff (!rstn)
        seqStay_s ##1 1'b1 |=> !rowStrobeN_ff) else $error("row dropped in page mode");
    precharge_a: assert property (@(posedge core_clk) disable iff (!rstn)
        cycleEnd && state_ff == ST_COL && !held_ff.seqHint && !resetHold |=> state_ff == ST_PRE)
        else $error("no precharge");
    idleNoCas_a: assert property (@(posedge core_clk) disable iff (!rstn)
        state_ff == ST_IDLE |=> colStrobeN_ff == 4'hf) else $error("cas in idle");
endmodule : mcc_cycle_ctrl

// ==== sim/mcc_cpu_model.sv ====
// behavioural processor core driving the address and control pins
// assumes phase two is seen on core_clk; the bench hands in the next request
`timescale 1ns/100ps
module mcc_cpu_model
    import mcc_pkg::*;
(
    input wire logic core_clk,
    input wire logic phase2Clk,
    input mcc_cpu_req_type nxtReq,
    output mcc_cpu_req_type pins
);
    logic ph2Last;
    initial pins = '{reqN: 1'b1, default: '0};
    // new request once phase two rises, held while it is low
    always @(posedge core_clk) begin
        ph2Last <= phase2Clk;
        if (phase2Clk && !ph2Last) begin
            pins <= nxtReq;
            // hint only when this address follows the last one by four
            pins.seqHint <= !nxtReq.reqN && (nxtReq.addr == pins.addr + 26'h4);
        end
    end
endmodule : mcc_cpu_model

// ==== sim/mcc_cycle_ctrl_bench.sv ====
// self-checking bench for the memory cycle sequencer with a processor model
// assumes the outputs settle within a few core clocks of each held request
`timescale 1ns/100ps
module mcc_cycle_ctrl_bench
    import mcc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic resetHold = 1'b1;
    logic pagePresent = 1'b1;
    mcc_cpu_req_type nxtReq = '{reqN: 1'b1, default: '0};
    mcc_cpu_req_type pins;
    logic ph1, ph2, refc, ras, dbe, fault, romSelN, ioN, pgL, osM, snd, bypass;
    logic [3:0] casN, lanesLow;
    logic [1:0] romSpd;
    logic [25:0] phys;
    logic rasLast, faultSeen, dbeSeen, bypassSeen;
    int fail_count = 0;
    int comparisons = 0;
    int rasFalls;

    always #10 core_clk = ~core_clk;

    mcc_cpu_model i_mcc_cpu_model (.core_clk(core_clk), .phase2Clk(ph2), .nxtReq(nxtReq),
        .pins(pins));
    mcc_cycle_ctrl i_mcc_cycle_ctrl (.core_clk(core_clk), .rstn(rstn), .cpu_addr(pins.addr),
        .cpu_read_not_write(pins.rdWrite), .cpu_byte_not_word(pins.byteWord),
        .cpu_cycle_request_n(pins.reqN), .sequential_hint(pins.seqHint),
        .supervisor_select(pins.superSel), .page_present(pagePresent), .reset_hold(resetHold),
        .phase1Clk_ff(ph1), .phase2Clk_ff(ph2), .refClk_ff(refc), .rowStrobeN_ff(ras),
        .colStrobeN_ff(casN), .cpu_bus_drive_enable_ff(dbe), .access_fault_ff(fault),
        .romSelectN_ff(romSelN), .io_cycle_request_n_ff(ioN), .romSpeed_ff(romSpd),
        .pageLarge_ff(pgL), .osMode_ff(osM), .soundEnable_ff(snd), .remapBypass_ff(bypass),
        .physAddr_ff(phys));

    // gather what the outputs did, sampled well after each edge
    always @(posedge core_clk) begin
        #2;
        faultSeen |= fault;
        dbeSeen |= dbe;
        bypassSeen |= bypass;
        lanesLow |= ~casN;
        if (rasLast && !ras) rasFalls++;
        rasLast = ras;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task tally_and_finish();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // one request per processor cycle, changed just after phase two rises
    task issue(input logic [25:0] a, input logic wr, input logic word, input logic sup);
        @(posedge ph2);
        @(negedge core_clk);
        nxtReq <= '{a, wr, word, 1'b0, 1'b0, sup};
    endtask : issue

    task settle();
        @(posedge ph2);
        @(negedge core_clk);
        nxtReq.reqN <= 1'b1;
        repeat (15) @(negedge core_clk);
    endtask : settle

    task access(input logic [25:0] a, input logic wr, input logic word, input logic sup);
        faultSeen = 0;
        dbeSeen = 0;
        bypassSeen = 0;
        lanesLow = 0;
        rasFalls = 0;
        issue(a, wr, word, sup);
        settle();
    endtask : access

    task t_reset();
        repeat (8) @(negedge core_clk);
        check("resetmodes", {romSpd, pgL, ioN, romSelN, osM, snd},
            {ROM_SLOW, PAGE_LARGE, 4'h8});
        resetHold <= 1'b0;
        repeat (8) @(negedge core_clk);
    endtask : t_reset

    task t_clocks();
        int n1, n2, bad;
        logic l1, l2;
        n1 = 0;
        n2 = 0;
        bad = 0;
        l1 = ph1;
        l2 = ph2;
        repeat (30) begin
            @(negedge core_clk);
            n1 += ph1;
            n2 += ph2;
            // three slots leave room for dead time only between phase one and two
            bad += (ph1 && ph2) || (l1 && ph2) || (refc !== ph2);
            l1 = ph1;
            l2 = ph2;
        end
        check("ph1count", n1, 10);
        check("ph2count", n2, 10);
        check("overlap", bad, 0);
    endtask : t_clocks

    task t_transfers();
        access(26'h0000107, 1'b1, 1'b1, 1'b1);
        check("wordwrite", {faultSeen, dbeSeen, bypassSeen, lanesLow}, 7'h3f);
        check("alignaddr", phys, 26'h0000104);
        for (int k = 0; k < 4; k++) begin
            access(26'h0000040 | k, 1'b1, 1'b0, 1'b0);
            check("bytelane", {faultSeen, dbeSeen, lanesLow}, {2'h1, 4'h1 << k});
        end
        access(26'h0000080, 1'b0, 1'b1, 1'b1);
        check("read", {faultSeen, dbeSeen}, 2'h0);
        access({REG_PRIV, 24'h000010}, 1'b0, 1'b1, 1'b0);
        check("userpriv", {faultSeen, lanesLow}, 5'h10);
        pagePresent <= 1'b0;
        access(26'h0000100, 1'b0, 1'b1, 1'b0);
        check("nopage", {faultSeen, lanesLow}, 5'h10);
        pagePresent <= 1'b1;
    endtask : t_transfers

    // page bursts keep the row open; scattered addresses reopen it each time
    task t_bursts(input logic [25:0] step, input int expFalls);
        rasFalls = 0;
        // scattered accesses need precharge room, so they are spaced apart
        for (int i = 0; i < 4; i++) begin
            issue(26'h0000100 + step * i, 1'b0, 1'b1, 1'b1);
            if (step != 26'h4) settle();
        end
        settle();
        check("rowopens", rasFalls, expFalls);
    endtask : t_bursts

    initial begin
        repeat (4) @(negedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_clocks();
        t_transfers();
        t_bursts(26'h4, 1);
        t_bursts(26'h100, 4);
        tally_and_finish();
    end

    // whole run is a few hundred cycles; this cuts a hang short
    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
endmodule : mcc_cycle_ctrl_bench
